// ### src/phy_timing_pkg.sv
// constants, carrier types and helpers for the line event timing block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package phy_timing_pkg;

  //----------------------------------------------------------------------------
  // clock and bit time
  //----------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BT100_NS = 10;
  localparam int unsigned BT10_NS = 100;
  // pin sync (4 edges) plus state and output registers
  localparam logic [7:0] PIPE_LAT = 8'h06;
  localparam int unsigned RX_DATA_PIPE = 5;

  //----------------------------------------------------------------------------
  // targets in tenths of a bit time, fast (100M) and slow (10M)
  //----------------------------------------------------------------------------
  localparam int unsigned CRS_ON_BT10_F = 140;
  localparam int unsigned CRS_ON_BT10_S = 150;
  localparam int unsigned CRS_OFF_BT10_F = 140;
  localparam int unsigned CRS_OFF_BT10_S = 80;
  localparam int unsigned DV_GAP_BT10_F = 40;
  localparam int unsigned DV_GAP_BT10_S = 180;
  localparam int unsigned DV_TAIL_BT10_F = 0;
  localparam int unsigned DV_TAIL_BT10_S = 4;
  localparam int unsigned COL_ON_BT10_F = 190;
  localparam int unsigned COL_ON_BT10_S = 160;
  localparam int unsigned COL_OFF_BT10_F = 180;
  localparam int unsigned COL_OFF_BT10_S = 75;
  localparam int unsigned CRS_TX_ON_BT10_F = 220;
  localparam int unsigned CRS_TX_ON_BT10_S = 30;
  localparam int unsigned CRS_TX_OFF_BT10_F = 260;
  localparam int unsigned CRS_TX_OFF_BT10_S = 20;
  localparam int unsigned RXD_LAT_BT10_S = 59;
  localparam int unsigned RXD_DLY =
    RXD_LAT_BT10_S * BT10_NS / 10 / CLK_PERIOD_NS - RX_DATA_PIPE;

  //----------------------------------------------------------------------------
  // long times
  //----------------------------------------------------------------------------
  localparam int unsigned JAB_MS = 100;
  localparam int unsigned UNJAB_MS = 500;
  localparam int unsigned SQE_START_NS = 1000;
  localparam int unsigned SQE_LEN_NS = 1000;
  localparam int unsigned FLP_PW_NS = 100;
  localparam int unsigned FLP_DATA_NS = 60000;
  localparam int unsigned FLP_CLK_US = 125;
  localparam int unsigned FLP_BURST_MS = 16;
  localparam int unsigned RECOVER_US = 250;
  localparam int unsigned FLP_SLOTS = 17;

  localparam int unsigned JAB_CYC_DEF = JAB_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned UNJAB_CYC_DEF = UNJAB_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned FLP_CLK_CYC_DEF = FLP_CLK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned FLP_BURST_CYC_DEF = FLP_BURST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC_DEF = RECOVER_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] SQE_START_CYC = 8'(SQE_START_NS / CLK_PERIOD_NS) - PIPE_LAT;
  localparam logic [7:0] SQE_END_CYC = SQE_START_CYC + 8'(SQE_LEN_NS / CLK_PERIOD_NS);
  localparam logic [12:0] FLP_PW_CYC = 13'(FLP_PW_NS / CLK_PERIOD_NS);
  localparam logic [12:0] FLP_DATA_CYC = 13'(FLP_DATA_NS / CLK_PERIOD_NS);

  //----------------------------------------------------------------------------
  // carriers
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic speed_100;
    logic heartbeat_en;
    logic autoneg_en;
    logic pair_rx_in;
    logic [3:0] rx_nib;
  } pin_in_s;

  typedef struct packed {
    logic crs;
    logic col;
    logic rx_dv;
    logic [3:0] rxd;
  } mii_rx_s;

  typedef struct packed {
    logic en;
    logic [3:0] data;
  } line_tx_s;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  function automatic logic [7:0] bt_cyc(input logic fast, input int unsigned bt10_f,
                                        input int unsigned bt10_s);
    int unsigned ns;
    ns = fast ? (bt10_f * BT100_NS / 10) : (bt10_s * BT10_NS / 10);
    return 8'(ns / CLK_PERIOD_NS);
  endfunction : bt_cyc

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : 8'(v + 8'h01);
  endfunction : sat_inc

endpackage : phy_timing_pkg

// ### src/phy_line_timing.sv
// line event timing core: carrier, collision, jabber (10M only), heartbeat (10M only), link pulses
`timescale 1ns/10ps
`default_nettype none
module phy_line_timing #(
  parameter int unsigned JAB_CYC = phy_timing_pkg::JAB_CYC_DEF,
  parameter int unsigned UNJAB_CYC = phy_timing_pkg::UNJAB_CYC_DEF,
  parameter int unsigned FLP_CLK_CYC = phy_timing_pkg::FLP_CLK_CYC_DEF,
  parameter int unsigned FLP_BURST_CYC = phy_timing_pkg::FLP_BURST_CYC_DEF,
  parameter int unsigned RECOVER_CYC = phy_timing_pkg::RECOVER_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mii_tx_clk_i,
  input wire phy_timing_pkg::pin_in_s pins_i,
  input wire logic mii_tx_en_i,
  input wire logic [3:0] mii_txd_i,
  input wire logic [15:0] an_word_i,
  output var phy_timing_pkg::mii_rx_s mii_rx_o,
  output var phy_timing_pkg::line_tx_s pair_tx_out_o,
  output logic link_pulse_o,
  output logic jabber_o,
  output logic mgmt_ready_o
);
  import phy_timing_pkg::*;

  //----------------------------------------------------------------------------
  // reset release, one copy per domain
  //----------------------------------------------------------------------------
  logic [1:0] rst_core_q;
  logic [1:0] rst_link_q;
  logic rst_core_b;
  logic rst_link_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_core_q <= 2'h0;
    end else begin
      rst_core_q <= {rst_core_q[0], 1'b1};
    end
  end

  always_ff @(posedge mii_tx_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_link_q <= 2'h0;
    end else begin
      rst_link_q <= {rst_link_q[0], 1'b1};
    end
  end

  assign rst_core_b = rst_core_q[1];
  assign rst_link_b = rst_link_q[1];

  //----------------------------------------------------------------------------
  // link side: transmit capture and line output
  //----------------------------------------------------------------------------
  logic tx_en_l;
  logic [3:0] txd_l;
  logic [2:0] jab_sync_l;
  logic jab_l;
  logic jabber;

  always_ff @(posedge mii_tx_clk_i or negedge rst_link_b) begin
    if (!rst_link_b) begin
      tx_en_l <= 1'b0;
      txd_l <= 4'h0;
    end else begin
      tx_en_l <= mii_tx_en_i;
      txd_l <= mii_txd_i;
    end
  end

  // jabber level into the link domain, taken once the last two stages agree
  always_ff @(posedge mii_tx_clk_i or negedge rst_link_b) begin
    if (!rst_link_b) begin
      jab_sync_l <= 3'h0;
      jab_l <= 1'b0;
    end else begin
      jab_sync_l <= {jab_sync_l[1:0], jabber};
      if (jab_sync_l[1] == jab_sync_l[2]) begin
        jab_l <= jab_sync_l[2];
      end
    end
  end

  // one link register from sampled enable to the line keeps latency short
  always_ff @(posedge mii_tx_clk_i or negedge rst_link_b) begin
    if (!rst_link_b) begin
      pair_tx_out_o <= '0;
    end else begin
      pair_tx_out_o.en <= tx_en_l && !jab_l;
      pair_tx_out_o.data <= (tx_en_l && !jab_l) ? txd_l : 4'h0;
    end
  end

  a_tx_latency: assert property (@(posedge mii_tx_clk_i) disable iff (!rst_link_b)
    tx_en_l && !jab_l |=> pair_tx_out_o.en && pair_tx_out_o.data == $past(txd_l))
    else $error("line output did not follow sampled enable");

  a_jab_block: assert property (@(posedge mii_tx_clk_i) disable iff (!rst_link_b)
    jab_l |=> !pair_tx_out_o.en)
    else $error("line driven while jabbering");

  //----------------------------------------------------------------------------
  // core side: pin and enable synchronisers
  //----------------------------------------------------------------------------
  pin_in_s pin_q1;
  pin_in_s pin_q2;
  pin_in_s pin_q3;
  pin_in_s pin_s;
  logic [2:0] tx_sync;
  logic tx_s;
  logic fast;
  logic rx_s;

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      pin_q1 <= '0;
      pin_q2 <= '0;
      pin_q3 <= '0;
      pin_s <= '0;
    end else begin
      pin_q1 <= pins_i;
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
      pin_s <= pin_in_s'((pin_q3 & ~(pin_q2 ^ pin_q3)) | (pin_s & (pin_q2 ^ pin_q3)));
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      tx_sync <= 3'h0;
      tx_s <= 1'b0;
    end else begin
      tx_sync <= {tx_sync[1:0], tx_en_l};
      if (tx_sync[1] == tx_sync[2]) begin
        tx_s <= tx_sync[2];
      end
    end
  end

  assign fast = pin_s.speed_100;
  assign rx_s = pin_s.pair_rx_in;

  //----------------------------------------------------------------------------
  // delays per speed, less the fixed pipeline except the data valid gap and tail
  //----------------------------------------------------------------------------
  logic [7:0] crs_on_c;
  logic [7:0] crs_off_c;
  logic [7:0] dv_gap_c;
  logic [7:0] dv_tail_c;
  logic [7:0] col_on_c;
  logic [7:0] col_off_c;
  logic [7:0] crs_tx_on_c;
  logic [7:0] crs_tx_off_c;

  always_comb begin
    crs_on_c = bt_cyc(fast, CRS_ON_BT10_F, CRS_ON_BT10_S) - PIPE_LAT;
    crs_off_c = bt_cyc(fast, CRS_OFF_BT10_F, CRS_OFF_BT10_S) - PIPE_LAT;
    dv_gap_c = bt_cyc(fast, DV_GAP_BT10_F, DV_GAP_BT10_S);
    dv_tail_c = bt_cyc(fast, DV_TAIL_BT10_F, DV_TAIL_BT10_S);
    col_on_c = bt_cyc(fast, COL_ON_BT10_F, COL_ON_BT10_S) - PIPE_LAT;
    col_off_c = bt_cyc(fast, COL_OFF_BT10_F, COL_OFF_BT10_S) - PIPE_LAT;
    crs_tx_on_c = bt_cyc(fast, CRS_TX_ON_BT10_F, CRS_TX_ON_BT10_S) - PIPE_LAT;
    crs_tx_off_c = bt_cyc(fast, CRS_TX_OFF_BT10_F, CRS_TX_OFF_BT10_S) - PIPE_LAT;
  end

  //----------------------------------------------------------------------------
  // edge timers, saturating; off timers start saturated so reset is quiet
  //----------------------------------------------------------------------------
  logic [7:0] rx_on_t;
  logic [7:0] rx_off_t;
  logic [7:0] tx_on_t;
  logic [7:0] tx_off_t;

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      rx_on_t <= 8'h00;
      rx_off_t <= 8'hFF;
    end else if (rx_s) begin
      rx_on_t <= sat_inc(rx_on_t);
      rx_off_t <= 8'h00;
    end else begin
      rx_on_t <= 8'h00;
      rx_off_t <= sat_inc(rx_off_t);
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      tx_on_t <= 8'h00;
      tx_off_t <= 8'hFF;
    end else if (tx_s) begin
      tx_on_t <= sat_inc(tx_on_t);
      tx_off_t <= 8'h00;
    end else begin
      tx_on_t <= 8'h00;
      tx_off_t <= sat_inc(tx_off_t);
    end
  end

  //----------------------------------------------------------------------------
  // carrier, data valid, collision, heartbeat
  //----------------------------------------------------------------------------
  logic crs_rx;
  logic crs_tx;
  logic rx_dv;
  logic col_rx;
  logic sqe;

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      crs_rx <= 1'b0;
    end else if (rx_s && rx_on_t >= crs_on_c) begin
      crs_rx <= 1'b1;
    end else if (!rx_s && rx_off_t >= crs_off_c) begin
      crs_rx <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      rx_dv <= 1'b0;
    end else if (rx_s && crs_rx && rx_on_t >= 8'(crs_on_c + dv_gap_c)) begin
      rx_dv <= 1'b1;
    end else if (!rx_s && rx_off_t >= 8'(crs_off_c - dv_tail_c)) begin
      rx_dv <= 1'b0;
    end
  end

  // collision needs both directions busy; it ends only when the line goes quiet
  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      col_rx <= 1'b0;
    end else if (tx_s && rx_s && rx_on_t >= col_on_c) begin
      col_rx <= 1'b1;
    end else if (!rx_s && rx_off_t >= col_off_c) begin
      col_rx <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      crs_tx <= 1'b0;
    end else if (tx_s && tx_on_t >= crs_tx_on_c) begin
      crs_tx <= 1'b1;
    end else if (!tx_s && tx_off_t >= crs_tx_off_c) begin
      crs_tx <= 1'b0;
    end
  end

  // tx_off_t passes the window once per frame end, giving one pulse per frame at 10M with heartbeat_en set and no jabber
  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      sqe <= 1'b0;
    end else begin
      sqe <= !fast && pin_s.heartbeat_en && !jabber && !tx_s &&
             tx_off_t >= SQE_START_CYC && tx_off_t < SQE_END_CYC;
    end
  end

  //----------------------------------------------------------------------------
  // receive data delay and MII outputs
  //----------------------------------------------------------------------------
  logic [3:0] rx_dly [RXD_DLY];

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      for (int i = 0; i < RXD_DLY; i++) begin
        rx_dly[i] <= 4'h0;
      end
    end else begin
      rx_dly[0] <= pin_s.rx_nib;
      for (int i = 1; i < RXD_DLY; i++) begin
        rx_dly[i] <= rx_dly[i - 1];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      mii_rx_o <= '0;
    end else begin
      mii_rx_o.crs <= crs_rx || crs_tx;
      mii_rx_o.col <= col_rx || sqe;
      mii_rx_o.rx_dv <= rx_dv;
      mii_rx_o.rxd <= rx_dv ? rx_dly[RXD_DLY - 1] : 4'h0;
    end
  end

  a_crs_rx_rise: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(crs_rx) |-> $past(rx_s) && $past(rx_on_t) == $past(crs_on_c))
    else $error("receive carrier rose at the wrong count");

  a_crs_rx_fall: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $fell(crs_rx) |-> !$past(rx_s) && $past(rx_off_t) == $past(crs_off_c))
    else $error("receive carrier fell at the wrong count");

  a_dv_gap: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(rx_dv) |-> crs_rx && $past(rx_on_t) == $past(8'(crs_on_c + dv_gap_c)))
    else $error("data valid not spaced from carrier");

  a_col_rise: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(col_rx) |-> $past(tx_s) && $past(rx_s) && $past(rx_on_t) >= $past(col_on_c))
    else $error("collision raised too early or without both directions");

  a_col_fall: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $fell(col_rx) |-> !$past(rx_s) && $past(rx_off_t) == $past(col_off_c))
    else $error("collision released at the wrong count");

  a_crs_tx_rise: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(crs_tx) |-> $past(tx_on_t) == $past(crs_tx_on_c))
    else $error("transmit carrier rose at the wrong count");

  a_crs_tx_fall: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $fell(crs_tx) |-> $past(tx_off_t) == $past(crs_tx_off_c))
    else $error("transmit carrier fell at the wrong count");

  a_rxd_tap: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    rx_dv |=> mii_rx_o.rx_dv && mii_rx_o.rxd == $past(rx_dly[RXD_DLY - 1]))
    else $error("receive nibble not from the delay tap");

  a_sqe_start: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(sqe) |-> $past(tx_off_t) == SQE_START_CYC)
    else $error("heartbeat started at the wrong count");

  a_sqe_end: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $fell(sqe) && !$past(tx_s) && $past(fast) == fast |-> $past(tx_off_t) == SQE_END_CYC)
    else $error("heartbeat length wrong");

  //----------------------------------------------------------------------------
  // jabber
  //----------------------------------------------------------------------------
  logic [24:0] jab_t;
  logic [24:0] unjab_t;

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      jab_t <= 25'h000_0000;
    end else if (!tx_s || fast) begin
      jab_t <= 25'h000_0000;
    end else if (!jabber) begin
      jab_t <= 25'(jab_t + 25'h000_0001);
    end
  end

  // any transmit activity while jabbering restarts the idle wait
  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      unjab_t <= 25'h000_0000;
    end else if (jabber && !tx_s) begin
      unjab_t <= 25'(unjab_t + 25'h000_0001);
    end else begin
      unjab_t <= 25'h000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      jabber <= 1'b0;
    end else if (!jabber && jab_t >= 25'(JAB_CYC)) begin
      jabber <= 1'b1;
    end else if (jabber && unjab_t >= 25'(UNJAB_CYC)) begin
      jabber <= 1'b0;
    end
  end

  assign jabber_o = jabber;

  a_jab_enter: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(jabber) |-> $past(jab_t) == 25'(JAB_CYC) && $past(tx_s))
    else $error("jabber entered at the wrong time");

  a_unjab: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $fell(jabber) |-> $past(unjab_t) == 25'(UNJAB_CYC) && !$past(tx_s))
    else $error("jabber left before the idle wait");

  //----------------------------------------------------------------------------
  // fast link pulse bursts
  //----------------------------------------------------------------------------
  logic [19:0] burst_t;
  logic [12:0] pulse_t;
  logic [4:0] slot;
  logic flp_run;
  logic link_pulse;

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      burst_t <= 20'h0_0000;
    end else if (!pin_s.autoneg_en || burst_t == 20'(FLP_BURST_CYC - 1)) begin
      burst_t <= 20'h0_0000;
    end else begin
      burst_t <= 20'(burst_t + 20'h0_0001);
    end
  end

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      flp_run <= 1'b0;
      slot <= 5'h00;
      pulse_t <= 13'h0000;
    end else if (!pin_s.autoneg_en) begin
      flp_run <= 1'b0;
      slot <= 5'h00;
      pulse_t <= 13'h0000;
    end else if (burst_t == 20'h0_0000) begin
      flp_run <= 1'b1;
      slot <= 5'h00;
      pulse_t <= 13'h0000;
    end else if (flp_run) begin
      if (pulse_t == 13'(FLP_CLK_CYC - 1)) begin
        pulse_t <= 13'h0000;
        if (slot == 5'(FLP_SLOTS - 1)) begin
          flp_run <= 1'b0;
        end else begin
          slot <= 5'(slot + 5'h01);
        end
      end else begin
        pulse_t <= 13'(pulse_t + 13'h0001);
      end
    end
  end

  // 17 clock pulses always; a data pulse follows each of the first 16 when set
  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      link_pulse <= 1'b0;
    end else begin
      link_pulse <= flp_run && (pulse_t < FLP_PW_CYC ||
                    (slot < 5'h10 && an_word_i[slot[3:0]] && pulse_t >= FLP_DATA_CYC &&
                     pulse_t < 13'(FLP_DATA_CYC + FLP_PW_CYC)));
    end
  end

  assign link_pulse_o = link_pulse;

  a_flp_clock: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    flp_run && pin_s.autoneg_en && pulse_t == 13'h0000 |=> link_pulse)
    else $error("clock pulse missing at slot start");

  a_flp_data: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    flp_run && slot < 5'h10 && pulse_t == FLP_DATA_CYC
    |=> link_pulse == $past(an_word_i[slot[3:0]]))
    else $error("data pulse does not match the code word");

  //----------------------------------------------------------------------------
  // recovery after reset or power up
  //----------------------------------------------------------------------------
  logic [13:0] rec_t;
  logic mgmt_ready;

  always_ff @(posedge clk_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      rec_t <= 14'h0000;
      mgmt_ready <= 1'b0;
    end else if (!mgmt_ready) begin
      if (rec_t == 14'(RECOVER_CYC - 1)) begin
        mgmt_ready <= 1'b1;
      end else begin
        rec_t <= 14'(rec_t + 14'h0001);
      end
    end
  end

  assign mgmt_ready_o = mgmt_ready;

  a_mgmt_ready: assert property (@(posedge clk_i) disable iff (!rst_core_b)
    $rose(mgmt_ready) |-> $past(rec_t) == 14'(RECOVER_CYC - 1))
    else $error("ready raised at the wrong count");

endmodule : phy_line_timing
`default_nettype wire

// ### test/mac_model.sv
// behavioural mac driving the mii transmit side
`timescale 1ns/10ps
`default_nettype none
module mac_model (
  input wire logic tx_clk_i,
  input wire logic ready_i,
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'h0;
  end
  // no frame before the recovery wait is over
  task automatic send(input int n);
    wait (ready_i === 1'b1);
    @(posedge tx_clk_i);
    #2;
    for (int i = 0; i < n; i++) begin
      tx_en_o = 1'b1;
      txd_o = 4'(i);
      @(posedge tx_clk_i);
      #2;
    end
    tx_en_o = 1'b0;
    txd_o = 4'h0;
  endtask : send
endmodule : mac_model
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the line event timing core
`timescale 1ns/10ps
`default_nettype none
module tb;
  import phy_timing_pkg::*;
  logic clk = 1'b0;
  logic txc = 1'b0;
  logic rst_b = 1'b0;
  logic en;
  logic [3:0] txd;
  logic [15:0] anw = 16'h0000;
  pin_in_s pins = 8'h40; // heartbeat on
  mii_rx_s rx;
  line_tx_s ltx;
  logic lp;
  logic jab;
  logic rdy;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  initial #7 forever #32 txc = ~txc;
  phy_line_timing #(.JAB_CYC(200), .UNJAB_CYC(400), .FLP_CLK_CYC(3010),
    .FLP_BURST_CYC(52000)) dut (.clk_i(clk), .rst_b_i(rst_b),
    .mii_tx_clk_i(txc), .pins_i(pins), .mii_tx_en_i(en), .mii_txd_i(txd),
    .an_word_i(anw), .mii_rx_o(rx), .pair_tx_out_o(ltx), .link_pulse_o(lp),
    .jabber_o(jab), .mgmt_ready_o(rdy));
  mac_model mac (.tx_clk_i(txc), .ready_i(rdy), .tx_en_o(en), .txd_o(txd));
  //----------------------------------------------------------------------------
  // helpers: fixed-phase drive, level compare, latency-range compare
  //----------------------------------------------------------------------------
  function automatic logic pk(input int k);
    case (k)
      0: return rx.crs;
      1: return rx.col;
      2: return rx.rx_dv;
      3: return lp;
      4: return jab;
      default: return rdy;
    endcase
  endfunction : pk
  task automatic drv(input logic s, input logic p);
    @(posedge clk);
    #2;
    pins.speed_100 = s;
    pins.pair_rx_in = p;
  endtask : drv
  task automatic chk(input logic a, input logic b);
    checks++;
    if (a !== b) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %b want %b", $time, a, b);
    end
  endtask : chk
  // bounded wait, so a stuck output ends the wait instead of hanging
  task automatic wt(input int k, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (pk(k) !== v && n <= hi) begin
      @(posedge clk);
      #1;
      n++;
    end
    checks++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("CHECK FAILED t=%0t output %0d after %0d cycles", $time, k, n);
    end
  endtask : wt
  task automatic s_rx100();
    drv(1'b1, 1'b1);
    wt(0, 1'b1, 6, 8);
    wt(2, 1'b1, 2, 2);
    drv(1'b1, 1'b0);
    wt(0, 1'b0, 5, 8);
    chk(rx.rx_dv, 1'b0);
  endtask : s_rx100
  task automatic s_col100();
    fork
      mac.send(60);
      begin
        wait (en === 1'b1);
        repeat (2) @(posedge txc);
        #1;
        chk(ltx.en, 1'b1);
        chk(ltx.data[0], 1'b0);
        @(posedge txc);
        #1;
        chk(ltx.data[0], 1'b1);
      end
      begin
        wait (en === 1'b1);
        @(posedge txc);
        wt(0, 1'b1, 10, 12);
      end
      begin
        wait (en === 1'b1);
        repeat (10) @(posedge clk);
        drv(1'b1, 1'b1);
        wt(1, 1'b1, 8, 11);
        drv(1'b1, 1'b0);
        wt(1, 1'b0, 9, 10);
      end
    join
    @(posedge txc);
    wt(0, 1'b0, 12, 14);
  endtask : s_col100
  task automatic s_rx10();
    // let the transmit off timer run past the heartbeat window before 10M
    repeat (300) @(posedge clk);
    #2;
    pins.rx_nib = 4'hA;
    drv(1'b0, 1'b1);
    wt(0, 1'b1, 10, 140);
    wt(2, 1'b1, 25, 160);
    @(posedge clk);
    #2;
    pins.rx_nib = 4'h5;
    repeat (28) @(posedge clk);
    #1;
    chk(rx.rxd == 4'hA, 1'b1);
    @(posedge clk);
    #1;
    chk(rx.rxd == 4'h5, 1'b1);
    drv(1'b0, 1'b0);
    wt(0, 1'b0, 30, 50);
  endtask : s_rx10
  task automatic s_col10();
    fork
      mac.send(60);
      begin
        wait (en === 1'b1);
        drv(1'b0, 1'b1);
        wt(1, 1'b1, 5, 155);
        drv(1'b0, 1'b0);
        wt(1, 1'b0, 25, 50);
        wait (en === 1'b0);
        wt(1, 1'b1, 32, 80);
        wt(1, 1'b0, 25, 75);
      end
    join
    @(posedge clk);
    #2;
    pins.heartbeat_en = 1'b0;
    mac.send(10);
    repeat (110) begin
      @(posedge clk);
      #1;
      chk(rx.col, 1'b0);
    end
  endtask : s_col10
  task automatic s_jab();
    fork
      mac.send(100);
      begin
        wait (en === 1'b1);
        wt(4, 1'b1, 200, 215);
        repeat (20) @(posedge clk);
        chk(ltx.en, 1'b0);
        wait (en === 1'b0);
        wt(4, 1'b0, 400, 415);
      end
    join
  endtask : s_jab
  task automatic s_flp();
    @(posedge clk);
    #2;
    anw = 16'h0001;
    pins.autoneg_en = 1'b1;
    wt(3, 1'b1, 1, 52000);
    wt(3, 1'b0, 5, 5);
    wt(3, 1'b1, 2995, 2995);
    wt(3, 1'b0, 5, 5);
    wt(3, 1'b1, 5, 5);
    wt(3, 1'b0, 5, 5);
    wt(3, 1'b1, 3005, 3005);
  endtask : s_flp
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #2;
    rst_b = 1'b1;
    wt(5, 1'b1, RECOVER_CYC_DEF + 1, RECOVER_CYC_DEF + 3);
    s_rx100();
    s_col100();
    s_rx10();
    s_col10();
    s_jab();
    s_flp();
    final_report();
  end
endmodule : tb
`default_nettype wire
